/* File: serial_defs.svh */
// Constants of the serial interrupt, DMA and clock block: register
// offsets, field positions, reset values and timing figures.
// Assumes inclusion by bare name from every file that needs them.
`ifndef SERIAL_DEFS_SVH
`define SERIAL_DEFS_SVH

// ----------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------
`define OFS_IRQ_MASK 12'h000
`define OFS_IRQ_STATUS 12'h004
`define OFS_CLOCK_CFG 12'h008
`define OFS_BAUD_LOW 12'h00c
`define OFS_BAUD_HIGH 12'h010
`define OFS_VECTOR 12'h014
`define OFS_DMA_CTRL 12'h018

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define BIT_HOLD_SEL 7
`define BIT_TXPIN_ROLE_HI 7
`define BIT_TXPIN_ROLE_LO 6
`define BIT_EXT_RX_EN 5
`define BIT_CLK_DIV 3
`define BIT_ECHO 1
`define BIT_LOOP 0
`define PEND_RX_ERR 0
`define PEND_ADDR_BRK 1
`define PEND_RX_DATA 2
`define PEND_TX_EMPTY 3
`define PEND_RX_EOB 4
`define PEND_TX_EOB 5

// ----------------------------------------------------------------
// Reset values and vector codes
// ----------------------------------------------------------------
`define RST_BYTE 8'h00
`define RST_VEC_BASE 5'h00
`define CODE_TX 3'h6
`define CODE_RX 3'h4
`define CODE_ADDR_BRK 3'h1
`define CODE_RX_ERR 3'h0

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define CLK_HZ 40000000
`define OVERSAMPLE 4'hf
`define INT_BAUD_MAX 350000
`define EXT_BAUD_MAX 175000
`define EXAMPLE_DIVISOR 16'h0032

`endif

/* File: serial_pkg.sv */
// Types shared by the serial interrupt, DMA and clock block.
// Assumes nothing beyond a SystemVerilog compiler.
package serial_pkg;

  // Role of the transmit clock pin, from two configuration bits
  typedef enum logic [1:0] {
    TXPIN_EXT_IN = 2'b00,
    TXPIN_BAUD_OUT = 2'b01,
    TXPIN_SYNC_OUT = 2'b10,
    TXPIN_SYNC_OUT_ALT = 2'b11
  } txpin_role_t;

  // One flag per interrupt source
  typedef logic [5:0] pend_vec_t;

endpackage : serial_pkg

/* File: serial_irq_if.sv */
// Carrier between the serial core and its priority encoder.
// Assumes both ends sit on the same clock.
`timescale 1ns/100ps
`default_nettype none
interface serial_irq_if;
  import serial_pkg::*;
  pend_vec_t active;   // Enabled and pending sources
  logic rx_dma_req;    // Receive DMA request
  logic tx_dma_req;    // Transmit DMA request
  logic [3:0] grant;   // One-hot winner
  logic [2:0] code;    // Low vector bits
  logic any;           // Some source pending
  modport core (output active, rx_dma_req, tx_dma_req,
                input grant, code, any);
  modport prio (input active, rx_dma_req, tx_dma_req,
                output grant, code, any);
endinterface : serial_irq_if
`default_nettype wire

/* File: serial_irq_prio.sv */
// Fixed internal priority and vector code of the serial block.
// Assumes the core presents only enabled, pending sources.
`timescale 1ns/100ps
`default_nettype none
`include "serial_defs.svh"
module serial_irq_prio
  import serial_pkg::*;
(
  // Link to the core
  serial_irq_if.prio bus
);
  // Receive group: error, address/break, data or end of block
  wire rx_irq = bus.active[`PEND_RX_ERR] | bus.active[`PEND_ADDR_BRK] |
                bus.active[`PEND_RX_DATA] | bus.active[`PEND_RX_EOB];
  wire tx_irq = bus.active[`PEND_TX_EMPTY] | bus.active[`PEND_TX_EOB];
  wire no_dma = ~bus.rx_dma_req & ~bus.tx_dma_req;

  // Receive DMA beats transmit DMA beats receive beats transmit
  assign bus.grant[0] = bus.rx_dma_req;
  assign bus.grant[1] = bus.tx_dma_req & ~bus.rx_dma_req;
  assign bus.grant[2] = rx_irq & no_dma;
  assign bus.grant[3] = tx_irq & ~rx_irq & no_dma;

  // Highest pending source shows first; the next once it is cleared
  assign bus.code = bus.active[`PEND_RX_ERR] ? `CODE_RX_ERR :
                    bus.active[`PEND_ADDR_BRK] ? `CODE_ADDR_BRK :
                    rx_irq ? `CODE_RX : `CODE_TX;
  assign bus.any = rx_irq | tx_irq;
endmodule : serial_irq_prio
`default_nettype wire

/* File: serial_baud_gen.sv */
// Sixteen-bit divide-by-n baud rate generator on the core clock.
// Assumes a divisor of zero means the generator is stopped.
`timescale 1ns/100ps
`default_nettype none
module serial_baud_gen (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Control
  input wire logic [15:0] divisor,
  input wire logic restart,
  // One pulse every divisor cycles
  output logic tick
);
  logic [15:0] cnt_reg;   // Cycles left to the next tick
  logic [15:0] cnt_next;

  // Reload on restart or on reaching zero
  assign tick = (cnt_reg == 16'h0000) && (divisor != 16'h0000) && !restart;
  assign cnt_next = (restart || cnt_reg == 16'h0000) ?
                    divisor - 16'h0001 : cnt_reg - 16'h0001;

  // Counter register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_reg <= 16'h0000;
    end else begin
      cnt_reg <= (divisor == 16'h0000) ? 16'h0000 : cnt_next;
    end
  end
endmodule : serial_baud_gen
`default_nettype wire

/* File: serial_comm_irq_dma_clocking.sv */
// Interrupt, DMA and clock logic of the serial interface, APB slave.
// Assumes the framing logic sends event pulses and serial data on
// pclk, and that a DMA controller watches the grant outputs.
//
// Function
// - Transmit event from holding or shift empty
// - Receive sources: data, errors, address/break
// - Vector codes x110, x100, x001, x000
// - Three hardware vector bits, 8-byte block
// - DMA end-of-block replaces character sources
// - Priority: rx DMA, tx DMA, rx, tx
// - Two DMA channels: transmit and receive
// - Divide bit clock by 16 or 1
// - Transmit clock pin has three roles
// - Configuration bit enables external receive clock
// - Sixteen-bit divide-by-n baud generator
// - Divisor byte write resets the interface
// - Internal 350k baud, external 175k baud
// - Divisor is clock over sixteen times baud
// - Echo routes serial input to output
// - Loopback joins transmitter and receiver internally
//
// The register addresses and register access over APB were decided locally.
`timescale 1ns/100ps
`default_nettype none
`include "serial_defs.svh"
module serial_comm_irq_dma_clocking
  import serial_pkg::*;
(
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Events from the framing logic, one-cycle pulses
  input wire logic tx_holding_empty,
  input wire logic tx_shift_empty,
  input wire logic rx_data_ready,
  input wire logic rx_error,
  input wire logic addr_break_match,
  // DMA channels: requests in, end-of-block pulses, grants out
  input wire logic rx_dma_req,
  input wire logic tx_dma_req,
  input wire logic rx_dma_eob,
  input wire logic tx_dma_eob,
  output logic rx_dma_grant,
  output logic tx_dma_grant,
  // Interrupt request and vector to the CPU
  output logic irq_req,
  output logic [7:0] irq_vector,
  // Bit timing and serial data towards the framing logic
  output logic tx_bit_tick,
  output logic rx_bit_tick,
  output logic sci_reset,
  input wire logic tx_serial_data,
  output logic rx_serial_data,
  // Serial pins
  input wire logic serial_input_pin,
  output logic serial_output_pin,
  input wire logic receive_clock_pin,
  input wire logic transmit_clock_pin_i,
  output logic transmit_clock_pin_o,
  output logic transmit_clock_pin_oe
);
  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  logic [7:0] serial_irq_mask_reg;     // Source enables, holding select
  pend_vec_t serial_irq_status_reg;    // Sticky pending flags
  pend_vec_t status_next;
  logic [7:0] serial_clock_config_reg; // Pin roles, divide, self test
  logic [7:0] baud_low_reg;            // Divisor low byte
  logic [7:0] baud_high_reg;           // Divisor high byte
  logic [4:0] vec_base_reg;            // Software part of the vector
  logic [1:0] dma_ctrl_reg;            // Bit 0 receive, bit 1 transmit
  logic [31:0] prdata_reg;             // Read data, loaded in setup
  logic sci_reset_reg;                 // Interface reset pulse
  logic irq_req_reg;
  logic [7:0] irq_vector_reg;
  logic pin_out_reg;                   // Serial output pin level
  logic rxd_reg;                       // Data seen by the receiver
  logic baud_tog_reg;                  // Baud clock on the pin
  logic sync_tog_reg;                  // Synchronous clock on the pin

  // ----------------------------------------------------------------
  // APB decode
  // ----------------------------------------------------------------
  wire setup = psel & ~penable;
  wire wr_acc = psel & penable & pwrite;
  wire hit_mask = paddr == `OFS_IRQ_MASK;
  wire hit_stat = paddr == `OFS_IRQ_STATUS;
  wire hit_clk = paddr == `OFS_CLOCK_CFG;
  wire hit_blo = paddr == `OFS_BAUD_LOW;
  wire hit_bhi = paddr == `OFS_BAUD_HIGH;
  wire hit_vec = paddr == `OFS_VECTOR;
  wire hit_dma = paddr == `OFS_DMA_CTRL;
  wire mapped = hit_mask | hit_stat | hit_clk | hit_blo | hit_bhi |
                hit_vec | hit_dma;
  wire baud_wr = wr_acc & (hit_blo | hit_bhi);

  // Zero wait state: read data was caught in the setup cycle
  assign pready = psel & penable;
  assign pslverr = psel & penable & ~mapped;
  assign prdata = prdata_reg;

  // Read mux, unmapped reads give zero
  wire [31:0] rd_mux =
    hit_mask ? {24'h000000, serial_irq_mask_reg} :
    hit_stat ? {26'h0, serial_irq_status_reg} :
    hit_clk ? {24'h000000, serial_clock_config_reg} :
    hit_blo ? {24'h000000, baud_low_reg} :
    hit_bhi ? {24'h000000, baud_high_reg} :
    hit_vec ? {24'h000000, irq_vector_reg} :
    hit_dma ? {30'h0, dma_ctrl_reg} : 32'h00000000;

  // ----------------------------------------------------------------
  // Configuration fields
  // ----------------------------------------------------------------
  wire hold_sel = serial_irq_mask_reg[`BIT_HOLD_SEL];
  wire dma_rx_on = dma_ctrl_reg[0];
  wire dma_tx_on = dma_ctrl_reg[1];
  wire clock_divide_select = serial_clock_config_reg[`BIT_CLK_DIV];
  wire ext_rx_on = serial_clock_config_reg[`BIT_EXT_RX_EN];
  wire echo_on = serial_clock_config_reg[`BIT_ECHO];
  wire loop_on = serial_clock_config_reg[`BIT_LOOP];
  txpin_role_t txpin_role;
  assign txpin_role = txpin_role_t'(serial_clock_config_reg[
                      `BIT_TXPIN_ROLE_HI:`BIT_TXPIN_ROLE_LO]);

  // ----------------------------------------------------------------
  // Register writes
  // ----------------------------------------------------------------
  // Control registers; a divisor byte write also pulses the reset
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      serial_irq_mask_reg <= `RST_BYTE;
      serial_clock_config_reg <= `RST_BYTE;
      baud_low_reg <= `RST_BYTE;
      baud_high_reg <= `RST_BYTE;
      vec_base_reg <= `RST_VEC_BASE;
      dma_ctrl_reg <= 2'h0;
      sci_reset_reg <= 1'b0;
    end else begin
      if (wr_acc && hit_mask) serial_irq_mask_reg <= pwdata[7:0];
      if (wr_acc && hit_clk) serial_clock_config_reg <= pwdata[7:0];
      if (wr_acc && hit_blo) baud_low_reg <= pwdata[7:0];
      if (wr_acc && hit_bhi) baud_high_reg <= pwdata[7:0];
      if (wr_acc && hit_vec) vec_base_reg <= pwdata[7:3];
      if (wr_acc && hit_dma) dma_ctrl_reg <= pwdata[1:0];
      sci_reset_reg <= baud_wr;
    end
  end
  assign sci_reset = sci_reset_reg;

  // Read data is sampled during the setup cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_reg <= 32'h00000000;
    end else if (setup) begin
      prdata_reg <= rd_mux;
    end
  end

  // ----------------------------------------------------------------
  // Interrupt sources
  // ----------------------------------------------------------------
  // Transmit empty follows the holding select bit
  wire tx_empty_evt = hold_sel ? tx_holding_empty : tx_shift_empty;
  pend_vec_t set_vec;
  assign set_vec[`PEND_RX_ERR] = rx_error;
  assign set_vec[`PEND_ADDR_BRK] = addr_break_match;
  assign set_vec[`PEND_RX_DATA] = rx_data_ready & ~dma_rx_on;
  assign set_vec[`PEND_TX_EMPTY] = tx_empty_evt & ~dma_tx_on;
  assign set_vec[`PEND_RX_EOB] = rx_dma_eob & dma_rx_on;
  assign set_vec[`PEND_TX_EOB] = tx_dma_eob & dma_tx_on;
  // Software writes ones to clear; hardware clears a flag only by the interface reset
  wire [5:0] clr_vec = (wr_acc && hit_stat) ? pwdata[5:0] : 6'h00;

  // Per flag: a set in the clearing cycle wins over the clear
  genvar gi;
  generate
    for (gi = 0; gi < 6; gi++) begin : g_pend
      assign status_next[gi] = set_vec[gi] |
                               (serial_irq_status_reg[gi] & ~clr_vec[gi]);
    end
  endgenerate

  // Pending flags, emptied by the interface reset
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      serial_irq_status_reg <= 6'h00;
    end else if (sci_reset_reg) begin
      serial_irq_status_reg <= 6'h00;
    end else begin
      serial_irq_status_reg <= status_next;
    end
  end

  // Only enabled sources of the current DMA mode take part
  pend_vec_t mode_keep;
  assign mode_keep = {dma_tx_on, dma_rx_on, ~dma_tx_on, ~dma_rx_on,
                      2'b11};
  serial_irq_if irq_bus ();
  assign irq_bus.active = serial_irq_status_reg & serial_irq_mask_reg[5:0]
                          & mode_keep;
  assign irq_bus.rx_dma_req = rx_dma_req & dma_rx_on;
  assign irq_bus.tx_dma_req = tx_dma_req & dma_tx_on;

  serial_irq_prio u_prio (
    .bus (irq_bus.prio)
  );

  // One channel for each direction
  assign rx_dma_grant = irq_bus.grant[0];
  assign tx_dma_grant = irq_bus.grant[1];

  // Vector: software base, hardware code in the low bits
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_req_reg <= 1'b0;
      irq_vector_reg <= 8'h00;
    end else begin
      irq_req_reg <= irq_bus.any;
      irq_vector_reg <= {vec_base_reg, irq_bus.code};
    end
  end
  assign irq_req = irq_req_reg;
  assign irq_vector = irq_vector_reg;

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  // Three stages; a level counts once stages two and three agree
  logic [2:0] pin_raw;
  logic [2:0] pin_lvl;
  logic [2:0] pin_rise;
  assign pin_raw = {transmit_clock_pin_i, receive_clock_pin,
                    serial_input_pin};
  generate
    for (gi = 0; gi < 3; gi++) begin : g_sync
      logic s1_reg, s2_reg, s3_reg, lvl_reg;
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          s1_reg <= 1'b1;
          s2_reg <= 1'b1;
          s3_reg <= 1'b1;
          lvl_reg <= 1'b1;
        end else begin
          s1_reg <= pin_raw[gi];
          s2_reg <= s1_reg;
          s3_reg <= s2_reg;
          if (s2_reg == s3_reg) lvl_reg <= s3_reg;
        end
      end
      assign pin_rise[gi] = (s2_reg == s3_reg) & s3_reg & ~lvl_reg;
      assign pin_lvl[gi] = lvl_reg;
    end
  endgenerate
  wire line_lvl = pin_lvl[0];

  // ----------------------------------------------------------------
  // Clock generation
  // ----------------------------------------------------------------
  // Software loads clock / (16 x baud), e.g. 50 for 9600 at 7.68 MHz
  wire baud_tick;
  serial_baud_gen u_baud (
    .pclk (pclk),
    .presetn (presetn),
    .divisor ({baud_high_reg, baud_low_reg}),
    .restart (sci_reset_reg),
    .tick (baud_tick)
  );

  // Sources; external edges are only trusted up to the lower rate
  wire [1:0] src_tick;
  assign src_tick[0] = (txpin_role == TXPIN_EXT_IN) ?
                       pin_rise[2] : baud_tick;
  assign src_tick[1] = ext_rx_on ? pin_rise[1] : baud_tick;

  // Per direction: pass every tick, or one in sixteen
  logic [1:0] bit_tick;
  generate
    for (gi = 0; gi < 2; gi++) begin : g_pre
      logic [3:0] pre_reg;
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          pre_reg <= 4'h0;
        end else if (sci_reset_reg) begin
          pre_reg <= 4'h0;
        end else if (src_tick[gi] && !clock_divide_select) begin
          pre_reg <= pre_reg + 4'h1;
        end
      end
      assign bit_tick[gi] = src_tick[gi] & ~sci_reset_reg &
                            (clock_divide_select |
                             (pre_reg == `OVERSAMPLE));
    end
  endgenerate
  assign tx_bit_tick = bit_tick[0];
  assign rx_bit_tick = bit_tick[1];

  // Square waves for the transmit clock pin
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      baud_tog_reg <= 1'b0;
      sync_tog_reg <= 1'b0;
    end else begin
      if (baud_tick) baud_tog_reg <= ~baud_tog_reg;
      if (tx_bit_tick) sync_tog_reg <= ~sync_tog_reg;
    end
  end

  // Pin role: input, baud output, or synchronous clock output
  assign transmit_clock_pin_oe = txpin_role != TXPIN_EXT_IN;
  assign transmit_clock_pin_o = (txpin_role == TXPIN_BAUD_OUT) ?
                                baud_tog_reg : sync_tog_reg;

  // ----------------------------------------------------------------
  // Self test paths
  // ----------------------------------------------------------------
  // Echo wins the pin; loopback parks it at mark and feeds the receiver
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_out_reg <= 1'b1;
      rxd_reg <= 1'b1;
    end else begin
      pin_out_reg <= echo_on ? line_lvl :
                     loop_on ? 1'b1 : tx_serial_data;
      rxd_reg <= loop_on ? tx_serial_data : line_lvl;
    end
  end
  assign serial_output_pin = pin_out_reg;
  assign rx_serial_data = rxd_reg;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence baud_byte_write;
    wr_acc && (hit_blo || hit_bhi);
  endsequence
  sequence iface_reset_seen;
    sci_reset ##1 (!sci_reset && serial_irq_status_reg == 6'h00);
  endsequence

  tx_holding_src_a: assert property (hold_sel && tx_holding_empty &&
    !dma_tx_on && !sci_reset |=> serial_irq_status_reg[`PEND_TX_EMPTY])
    else $error("transmit empty not flagged");
  rx_error_src_a: assert property (rx_error && !sci_reset |=>
    serial_irq_status_reg[`PEND_RX_ERR])
    else $error("receive error not flagged");
  vec_code_a: assert property (irq_bus.active[`PEND_RX_ERR] |=>
    irq_vector[2:0] == 3'h0 || sci_reset)
    else $error("receive error vector code wrong");
  vec_base_a: assert property (##1 irq_vector[7:3] ==
    $past(vec_base_reg))
    else $error("vector base bits wrong");
  dma_swap_a: assert property (dma_rx_on &&
    !serial_irq_status_reg[`PEND_RX_DATA] |=>
    !serial_irq_status_reg[`PEND_RX_DATA])
    else $error("data source active during DMA");
  dma_prio_a: assert property (rx_dma_req && dma_rx_on |->
    rx_dma_grant && !tx_dma_grant && !irq_bus.grant[2])
    else $error("receive DMA not highest");
  div16_a: assert property (tx_bit_tick && !clock_divide_select
    |-> g_pre[0].pre_reg == 4'hf)
    else $error("divide by sixteen broken");
  baud_reset_a: assert property (baud_byte_write |=>
    iface_reset_seen)
    else $error("divisor write did not reset");
  echo_path_a: assert property (echo_on |=>
    serial_output_pin == $past(line_lvl))
    else $error("echo path broken");
  loop_path_a: assert property (loop_on && !echo_on |=>
    serial_output_pin && rx_serial_data == $past(tx_serial_data))
    else $error("loopback path broken");
endmodule : serial_comm_irq_dma_clocking
`default_nettype wire

/* File: serial_far_end.sv */
// Far-end serial equipment: drives the line and a receive clock.
// Assumes the bench sets level and run between frames.
`timescale 1ns/100ps
`default_nettype none
module serial_far_end (
  // Control from the bench
  input wire logic run,
  input wire logic level,
  // Serial pins
  output logic ser_line,
  output logic rx_clk
);
  // Line always driven to the wanted level, so it is never left floating
  assign ser_line = level;
  // Clock of 200 ns runs only inside a frame, else stands low
  initial rx_clk = 1'b0;
  always #100 rx_clk = run ? ~rx_clk : 1'b0;
endmodule : serial_far_end
`default_nettype wire

/* File: serial_comm_irq_dma_clocking_tb.sv */
// Bench of the serial interrupt, DMA and clock block over APB.
// Assumes the far-end model and the design files compile first.
`timescale 1ns/100ps
`default_nettype none
`include "serial_defs.svh"
module serial_comm_irq_dma_clocking_tb;
  import serial_pkg::*;
  // ---
  // Signals
  // ---
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [6:0] ev = 7'h00; // Tx eob, rx eob, addr, err, data, shift, hold
  logic [1:0] dreq = 2'b00; // Rx and tx DMA requests
  logic txd = 1'b1;
  logic run = 1'b0;
  logic level = 1'b1;
  logic ser_line, far_clk, txpin_i, err_seen, pready, pslverr, rgnt, tgnt;
  logic irq, sres, rxt, txt, rxd, pin_out, tpo, tpoe;
  logic [31:0] prdata;
  logic [7:0] vec;
  int bad_count = 0;
  int checked = 0;
  int cyc = 0;
  int rticks = 0;
  int tticks = 0;
  int resets = 0;
  int n0;
  logic [2:0] codes [4] = '{3'h0, 3'h1, 3'h4, 3'h6};
  logic [7:0] roles [4] = '{8'h00, 8'h40, 8'h80, 8'hc0};
  // Nobody else drives the clock pin, so it rests low when released
  assign txpin_i = tpoe ? tpo : 1'b0;
  always #12.5 pclk = ~pclk;
  serial_comm_irq_dma_clocking i_dut (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .tx_holding_empty(ev[0]), .tx_shift_empty(ev[1]),
    .rx_data_ready(ev[2]), .rx_error(ev[3]), .addr_break_match(ev[4]),
    .rx_dma_req(dreq[1]), .tx_dma_req(dreq[0]), .rx_dma_eob(ev[5]),
    .tx_dma_eob(ev[6]), .rx_dma_grant(rgnt), .tx_dma_grant(tgnt),
    .irq_req(irq), .irq_vector(vec), .tx_bit_tick(txt), .rx_bit_tick(rxt),
    .sci_reset(sres), .tx_serial_data(txd), .rx_serial_data(rxd),
    .serial_input_pin(ser_line), .serial_output_pin(pin_out),
    .receive_clock_pin(far_clk), .transmit_clock_pin_i(txpin_i),
    .transmit_clock_pin_o(tpo), .transmit_clock_pin_oe(tpoe));
  serial_far_end i_far (.run(run), .level(level), .ser_line(ser_line),
    .rx_clk(far_clk));
  // Cycle, tick and reset-pulse counters; ceiling cuts a hang short
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (rxt === 1'b1) rticks <= rticks + 1;
    if (txt === 1'b1) tticks <= tticks + 1;
    if (sres === 1'b1) resets <= resets + 1;
    if (cyc == 20000) begin
      bad_count = bad_count + 1;
      end_of_test();
    end
  end
  // ---
  // Tasks
  // ---
  task automatic chk(input string n, input logic [31:0] e,
                     input logic [31:0] g);
    checked++;
    if (g !== e) begin
      $display("mismatch %s expected %h seen %h", n, e, g);
      bad_count++;
    end
  endtask : chk
  // One APB transfer; request held until pready is sampled high
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d, output logic [31:0] r);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    r = prdata;
    err_seen = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] r;
    apb(1'b1, a, d, r);
  endtask : wr
  task automatic rd(input logic [11:0] a, input logic [31:0] e,
                    input string n);
    logic [31:0] r;
    apb(1'b0, a, 32'h0, r);
    chk(n, e, r);
  endtask : rd
  task automatic pulse(input logic [6:0] m);
    @(posedge pclk);
    ev <= m;
    @(posedge pclk);
    ev <= 7'h00;
  endtask : pulse
  task automatic cycles(input int n);
    repeat (n) @(posedge pclk);
  endtask : cycles
  task end_of_test;
    $display("checked %0d bad_count %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : end_of_test
  // ---
  // Scenarios
  // ---
  initial begin
    cycles(2);
    presetn <= 1'b1;
    // With nothing pending the vector shows the transmit code
    for (int a = 0; a < 28; a += 4)
      rd(a[11:0], (a == `OFS_VECTOR) ? {29'h0, `CODE_TX} : 32'h0,
         "reset value");
    rd(12'h01c, 32'h0, "unmapped read");
    chk("slave error", 32'h1, {31'h0, err_seen});
    // All character sources at once, served highest first
    wr(`OFS_VECTOR, 32'ha8);
    wr(`OFS_IRQ_MASK, 32'h0f);
    pulse(7'h1f);
    for (int i = 0; i < 4; i++) begin
      cycles(3);
      chk("vector", {24'h0, 5'h15, codes[i]}, {24'h0, vec});
      wr(`OFS_IRQ_STATUS, 32'h1 << i);
    end
    cycles(3);
    chk("holding ignored", 32'h0, {31'h0, irq});
    wr(`OFS_IRQ_MASK, 32'h88);
    pulse(7'h02);
    cycles(3);
    chk("shift ignored", 32'h0, {31'h0, irq});
    pulse(7'h01);
    cycles(3);
    chk("holding vector", 32'hae, {24'h0, vec});
    wr(`OFS_IRQ_STATUS, 32'h08);
    // DMA end-of-block replaces character sources
    wr(`OFS_DMA_CTRL, 32'h3);
    wr(`OFS_IRQ_MASK, 32'hbc);
    pulse(7'h05);
    cycles(3);
    chk("dma masks data", 32'h0, {31'h0, irq});
    pulse(7'h60);
    cycles(3);
    chk("rx eob vector", 32'hac, {24'h0, vec});
    wr(`OFS_IRQ_STATUS, 32'h10);
    cycles(3);
    chk("tx eob vector", 32'hae, {24'h0, vec});
    wr(`OFS_IRQ_STATUS, 32'h20);
    @(posedge pclk) dreq <= 2'b11;
    @(posedge pclk);
    chk("grants", 32'h2, {30'h0, rgnt, tgnt});
    dreq <= 2'b01;
    @(posedge pclk);
    chk("tx grant", 32'h1, {30'h0, rgnt, tgnt});
    dreq <= 2'b00;
    // Divisor writes reset the interface and clear pending state
    wr(`OFS_IRQ_MASK, 32'h01);
    pulse(7'h08);
    n0 = resets;
    wr(`OFS_BAUD_HIGH, 32'h0);
    wr(`OFS_BAUD_LOW, 32'h2);
    cycles(2);
    chk("reset pulses", 32'd2, resets - n0);
    rd(`OFS_IRQ_STATUS, 32'h0, "status after reset");
    // Bit rate of divisor 2: by 1 then by 16, then external clock
    wr(`OFS_CLOCK_CFG, 32'h08);
    cycles(4);
    n0 = rticks;
    cycles(64);
    chk("ticks by 1", 32'd32, rticks - n0);
    wr(`OFS_CLOCK_CFG, 32'h00);
    cycles(4);
    n0 = rticks;
    cycles(320);
    chk("ticks by 16", 32'd10, rticks - n0);
    wr(`OFS_CLOCK_CFG, 32'h28);
    run <= 1'b1;
    cycles(16);
    n0 = rticks;
    cycles(160);
    run <= 1'b0;
    n0 = rticks - n0;
    chk("ext ticks", 32'h1, {31'h0, n0 >= 19 && n0 <= 21});
    for (int i = 0; i < 4; i++) begin
      wr(`OFS_CLOCK_CFG, {24'h0, roles[i]});
      cycles(2);
      chk("pin drive", {31'h0, i > 0}, {31'h0, tpoe});
      // Baud output flips once per baud tick, i.e. every two cycles
      n0 = tpo;
      cycles(2);
      if (i < 2) chk("pin clock", {31'h0, n0[0] ^ (i == 1)}, {31'h0, tpo});
    end
    // Internal source divided by sixteen feeds the transmitter
    n0 = tticks;
    cycles(320);
    chk("tx ticks", 32'd10, tticks - n0);
    // Self test: echo, loopback, both
    txd <= 1'b0;
    wr(`OFS_CLOCK_CFG, 32'h02);
    cycles(6);
    chk("echo high", 32'h1, {31'h0, pin_out});
    level <= 1'b0;
    cycles(6);
    chk("echo low", 32'h0, {31'h0, pin_out});
    level <= 1'b1;
    wr(`OFS_CLOCK_CFG, 32'h01);
    cycles(6);
    chk("loop", 32'h2, {30'h0, pin_out, rxd});
    level <= 1'b0;
    txd <= 1'b1;
    wr(`OFS_CLOCK_CFG, 32'h03);
    cycles(6);
    chk("echo and loop", 32'h1, {30'h0, pin_out, rxd});
    end_of_test();
  end
endmodule : serial_comm_irq_dma_clocking_tb
`default_nettype wire
